/* src/phy_strap_latch_led_ctrl.sv */
`default_nettype none
module phy_strap_latch_led_ctrl #(
  parameter int BLINK_CYCLES = strap_led_pkg::BLINK_HALF_CYC
) (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst,
  // strap inputs
  input  wire logic                   addr_strap_bit2,
  input  wire logic                   addr_strap_bit1,
  input  wire logic                   addr_strap_bit0,
  input  wire logic [2:0]             mode_strap,
  input  wire logic                   isolate_strap,
  input  wire logic                   speed_strap,
  input  wire logic                   duplex_strap,
  input  wire logic                   autoneg_enable_strap,
  // line status
  input  wire logic                   link_up,
  input  wire logic                   link_speed_100,
  input  wire logic                   activity,
  // register port
  input  wire logic [4:0]             reg_addr,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [15:0]            reg_wdata,
  output logic      [15:0]            reg_rdata,
  output logic                        reg_rvalid,
  // configuration results
  output logic      [4:0]             mgmt_addr,
  output strap_led_pkg::if_mode_e     if_mode,
  output logic                        straps_latched,
  // led pins, low is lit
  output logic                        speed_or_activity_led_out,
  output logic                        link_activity_led_out
);
  localparam int CW = $clog2(BLINK_CYCLES + 1);
  localparam logic [CW-1:0] BLINK_LAST = CW'(BLINK_CYCLES - 1);

  // mode strap decode, shared with checks
  function automatic strap_led_pkg::if_mode_e decode_mode(
    input logic [2:0] code
  );
    case (code)
      strap_led_pkg::STRAP_MII:     decode_mode = strap_led_pkg::MODE_MII;
      strap_led_pkg::STRAP_RMII:    decode_mode = strap_led_pkg::MODE_RMII;
      strap_led_pkg::STRAP_PCS_LPB:
        decode_mode = strap_led_pkg::MODE_PCS_LOOPBACK;
      default:                      decode_mode = strap_led_pkg::MODE_RESERVED;
    endcase
  endfunction : decode_mode

  logic [15:0] basic_control, next_basic_control;
  logic [15:0] autoneg_adv, next_autoneg_adv;
  logic [15:0] led_control, next_led_control;
  logic [4:0]  next_mgmt_addr;
  strap_led_pkg::if_mode_e next_if_mode;
  logic        next_straps_latched;
  logic [15:0] next_reg_rdata;
  logic        next_reg_rvalid;
  logic        wr_bc, wr_adv, wr_led;

  assign wr_bc  = reg_wr && reg_addr == strap_led_pkg::OFS_BASIC_CONTROL;
  assign wr_adv = reg_wr && reg_addr == strap_led_pkg::OFS_AUTONEG_ADV;
  assign wr_led = reg_wr && reg_addr == strap_led_pkg::OFS_LED_CONTROL;

  // strap capture on first cycle after reset, then register writes
  always_comb begin
    next_basic_control  = basic_control;
    next_autoneg_adv    = autoneg_adv;
    next_led_control    = led_control;
    next_mgmt_addr      = mgmt_addr;
    next_if_mode        = if_mode;
    next_straps_latched = 1'b1;
    if (!straps_latched) begin
      next_mgmt_addr = {strap_led_pkg::ADDR_UPPER, addr_strap_bit2,
                        addr_strap_bit1, addr_strap_bit0};
      next_if_mode = decode_mode(mode_strap);
      next_basic_control[strap_led_pkg::BC_ISOLATE_BIT] = isolate_strap;
      next_basic_control[strap_led_pkg::BC_SPEED_BIT] = speed_strap;
      next_basic_control[strap_led_pkg::BC_DUPLEX_BIT] = duplex_strap;
      next_basic_control[strap_led_pkg::BC_ANEG_BIT] = autoneg_enable_strap;
      next_autoneg_adv = strap_led_pkg::ADV_BASE;
      next_autoneg_adv[strap_led_pkg::ADV_100_HI] = speed_strap;
      next_autoneg_adv[strap_led_pkg::ADV_100_LO] = speed_strap;
    end else begin
      if (wr_bc)  next_basic_control = reg_wdata;
      if (wr_adv) next_autoneg_adv   = reg_wdata;
      if (wr_led) next_led_control   = reg_wdata;
    end
  end

  // read answer, unmapped reads as zero
  always_comb begin
    next_reg_rvalid = reg_rd;
    next_reg_rdata  = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        strap_led_pkg::OFS_BASIC_CONTROL: next_reg_rdata = basic_control;
        strap_led_pkg::OFS_AUTONEG_ADV:   next_reg_rdata = autoneg_adv;
        strap_led_pkg::OFS_LED_CONTROL:   next_reg_rdata = led_control;
        default:                          next_reg_rdata = 16'h0000;
      endcase
    end
  end

  // register state
  always_ff @(posedge mclk) begin
    if (rst) begin
      basic_control  <= strap_led_pkg::BASIC_CONTROL_RST;
      autoneg_adv    <= strap_led_pkg::ADV_BASE;
      led_control    <= strap_led_pkg::LED_CONTROL_RST;
      mgmt_addr      <= strap_led_pkg::MGMT_ADDR_RST;
      if_mode        <= strap_led_pkg::MODE_MII;
      straps_latched <= 1'b0;
      reg_rdata      <= 16'h0000;
      reg_rvalid     <= 1'b0;
    end else begin
      basic_control  <= next_basic_control;
      autoneg_adv    <= next_autoneg_adv;
      led_control    <= next_led_control;
      mgmt_addr      <= next_mgmt_addr;
      if_mode        <= next_if_mode;
      straps_latched <= next_straps_latched;
      reg_rdata      <= next_reg_rdata;
      reg_rvalid     <= next_reg_rvalid;
    end
  end

  logic [1:0]    led_mode;
  logic [CW-1:0] blink_cnt, next_blink_cnt;
  logic          blink, next_blink;
  logic          next_speed_or_activity_led_out;
  logic          next_link_activity_led_out;

  assign led_mode = led_control[strap_led_pkg::LED_MODE_HI:
                                strap_led_pkg::LED_MODE_LO];

  // led drive and blink timer
  always_comb begin
    next_blink_cnt = '0;
    next_blink     = 1'b0;
    next_speed_or_activity_led_out = 1'b1;
    next_link_activity_led_out     = 1'b1;
    if (link_up && activity) begin
      next_blink     = blink;
      next_blink_cnt = blink_cnt + CW'(1);
      if (blink_cnt == BLINK_LAST) begin
        next_blink_cnt = '0;
        next_blink     = !blink;
      end
    end
    case (led_mode)
      strap_led_pkg::LED_MODE_SPEED_LINK: begin
        next_speed_or_activity_led_out = !link_speed_100;
        next_link_activity_led_out = !link_up || (activity && blink);
      end
      strap_led_pkg::LED_MODE_ACT_LINK: begin
        next_speed_or_activity_led_out = !activity;
        next_link_activity_led_out     = !link_up;
      end
      default: begin
        next_speed_or_activity_led_out = 1'b1;
        next_link_activity_led_out     = 1'b1;
      end
    endcase
  end

  // led registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      blink_cnt                 <= '0;
      blink                     <= 1'b0;
      speed_or_activity_led_out <= 1'b1;
      link_activity_led_out     <= 1'b1;
    end else begin
      blink_cnt                 <= next_blink_cnt;
      blink                     <= next_blink;
      speed_or_activity_led_out <= next_speed_or_activity_led_out;
      link_activity_led_out     <= next_link_activity_led_out;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_addr_upper_zero: assert property (mgmt_addr[4:3] == 2'h0)
    else $error("address upper bits not zero");
  a_addr_latch_value: assert property ($rose(straps_latched) |->
    mgmt_addr[2:0] == $past({addr_strap_bit2, addr_strap_bit1,
                             addr_strap_bit0}))
    else $error("address strap not latched");
  a_mode_decode_ok: assert property ($rose(straps_latched) |->
    if_mode == decode_mode($past(mode_strap)))
    else $error("interface mode wrong");
  a_isolate_latch: assert property ($rose(straps_latched) |->
    basic_control[strap_led_pkg::BC_ISOLATE_BIT] == $past(isolate_strap))
    else $error("isolate bit wrong");
  a_speed_latch: assert property ($rose(straps_latched) |->
    basic_control[strap_led_pkg::BC_SPEED_BIT] == $past(speed_strap))
    else $error("speed bit wrong");
  a_adv_speed_follow: assert property ($rose(straps_latched) |->
    autoneg_adv[strap_led_pkg::ADV_100_HI] == $past(speed_strap) &&
    autoneg_adv[strap_led_pkg::ADV_100_LO] == $past(speed_strap))
    else $error("advertised speed wrong");
  a_duplex_latch: assert property ($rose(straps_latched) |->
    basic_control[strap_led_pkg::BC_DUPLEX_BIT] == $past(duplex_strap))
    else $error("duplex bit wrong");
  a_aneg_latch: assert property ($rose(straps_latched) |->
    basic_control[strap_led_pkg::BC_ANEG_BIT] ==
    $past(autoneg_enable_strap))
    else $error("autoneg bit wrong");
  a_led_reserved_off: assert property (led_mode[1] |=>
    speed_or_activity_led_out && link_activity_led_out)
    else $error("reserved mode lit led");
  a_speed_led_mode0: assert property (led_mode == 2'h0 |=>
    speed_or_activity_led_out == !$past(link_speed_100))
    else $error("speed led wrong");
  a_link_led_mode0: assert property (
    led_mode == 2'h0 && !activity |=>
    link_activity_led_out == !$past(link_up))
    else $error("link led wrong");
  a_link_led_mode1: assert property (led_mode == 2'h1 |=>
    link_activity_led_out == !$past(link_up) &&
    speed_or_activity_led_out == !$past(activity))
    else $error("mode 01 leds wrong");

  c_rmii_latched: cover property ($rose(straps_latched) &&
    if_mode == strap_led_pkg::MODE_RMII);
  c_loopback_latched: cover property ($rose(straps_latched) &&
    if_mode == strap_led_pkg::MODE_PCS_LOOPBACK);
  c_link_blink: cover property (led_mode == 2'h0 && $changed(blink));
  c_mode1_activity: cover property (led_mode == 2'h1 && activity);
endmodule : phy_strap_latch_led_ctrl
`default_nettype wire

/* src/strap_led_pkg.sv */
// Summary of operation
// - latch three address straps after reset, 0..7
// - upper address bits forced zero, default 00001
// - mode straps decode 000 MII, 001 RMII, 100 loopback
// - isolate strap latched into control bit 10
// - speed strap latched into control bit 13
// - speed strap also sets advertised speed capability
// - duplex strap latched into control bit 8
// - autoneg strap latched into control bit 12
// - led mode from led control bits 15:14
`default_nettype none
package strap_led_pkg;
  // register offsets on the management register port
  localparam logic [4:0] OFS_BASIC_CONTROL = 5'h00;
  localparam logic [4:0] OFS_AUTONEG_ADV   = 5'h04;
  localparam logic [4:0] OFS_LED_CONTROL   = 5'h1e;
  // basic control field positions
  localparam int BC_SPEED_BIT   = 13;
  localparam int BC_ANEG_BIT    = 12;
  localparam int BC_ISOLATE_BIT = 10;
  localparam int BC_DUPLEX_BIT  = 8;
  // advertisement fields
  localparam int ADV_100_HI = 8;
  localparam int ADV_100_LO = 7;
  localparam logic [15:0] ADV_BASE = 16'h0061; // 10 half/full, selector
  // led control field
  localparam int LED_MODE_HI = 15;
  localparam int LED_MODE_LO = 14;
  localparam logic [1:0] LED_MODE_SPEED_LINK = 2'h0;
  localparam logic [1:0] LED_MODE_ACT_LINK   = 2'h1;
  // reset values
  localparam logic [15:0] BASIC_CONTROL_RST = 16'h0000;
  localparam logic [15:0] LED_CONTROL_RST   = 16'h0000;
  localparam logic [4:0]  MGMT_ADDR_RST     = 5'h01;
  localparam logic [1:0]  ADDR_UPPER        = 2'h0;
  // interface mode strap codes
  localparam logic [2:0] STRAP_MII     = 3'h0;
  localparam logic [2:0] STRAP_RMII    = 3'h1;
  localparam logic [2:0] STRAP_PCS_LPB = 3'h4;
  typedef enum logic [1:0] {
    MODE_MII, MODE_RMII, MODE_PCS_LOOPBACK, MODE_RESERVED
  } if_mode_e;
  // timing
  localparam int CLK_PERIOD_NS  = 20;
  localparam int BLINK_HALF_NS  = 20_000_000;
  localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;
endpackage : strap_led_pkg
`default_nettype wire

/* verification/board_straps.sv */
`default_nettype none
module board_straps (
  // jumper choices from the bench
  input  wire logic [2:0] addr_sel,
  input  wire logic [2:0] mode_sel,
  input  wire logic [3:0] misc_sel,
  // strap levels to the device
  output logic      [2:0] addr_pins,
  output logic      [2:0] mode_pins,
  output logic      [3:0] misc_pins,
  // led pins in, lamp state out
  input  wire logic [1:0] led_pins,
  output logic      [1:0] led_lit
);
  timeunit 1ns;
  timeprecision 1ns;
  // address jumpers straight onto the straps
  assign addr_pins = addr_sel;
  assign mode_pins = (mode_sel inside {3'h0, 3'h1, 3'h4}) ? mode_sel : 3'h0;
  // isolate, speed, duplex, autoneg levels
  assign misc_pins = misc_sel;
  // a lamp glows on a low pin
  assign led_lit = ~led_pins;
endmodule : board_straps
`default_nettype wire

/* verification/phy_strap_latch_led_ctrl_test.sv */
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  mismatches++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module phy_strap_latch_led_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, rst, reg_wr, reg_rd, link_up, link_speed_100, activity;
  logic        reg_rvalid, straps_latched;
  logic        speed_or_activity_led_out, link_activity_led_out;
  logic [4:0]  reg_addr, mgmt_addr;
  logic [15:0] reg_wdata, reg_rdata, v;
  logic [2:0]  addr_sel, mode_sel, addr_pins, mode_pins;
  logic [3:0]  misc_sel, misc_pins;
  logic [1:0]  led_lit, m;
  int          mismatches, n_tests, lit;
  strap_led_pkg::if_mode_e if_mode;
  // device under test, short blink count
  phy_strap_latch_led_ctrl #(.BLINK_CYCLES(4)) uut (.mclk, .rst,
    .addr_strap_bit2(addr_pins[2]), .addr_strap_bit1(addr_pins[1]),
    .addr_strap_bit0(addr_pins[0]), .mode_strap(mode_pins),
    .isolate_strap(misc_pins[3]), .speed_strap(misc_pins[2]),
    .duplex_strap(misc_pins[1]), .autoneg_enable_strap(misc_pins[0]),
    .link_up, .link_speed_100, .activity, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .reg_rvalid, .mgmt_addr, .if_mode,
    .straps_latched, .speed_or_activity_led_out, .link_activity_led_out);
  // board jumpers and lamps
  board_straps board (.addr_sel, .mode_sel, .misc_sel, .addr_pins,
    .mode_pins, .misc_pins, .led_lit,
    .led_pins({speed_or_activity_led_out, link_activity_led_out}));
  // clock
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  // verdict and end of run
  task automatic results();
    if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // one write strobe
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask : wr
  // one read strobe, compared with the model
  task automatic chk_rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1;
    `CHK("rvalid", 1'h1, reg_rvalid)
    `CHK("rdata", e, reg_rdata)
  endtask : chk_rd
  // reset with chosen jumpers, then check latched results
  task automatic restart(input logic [2:0] a, md, input logic [3:0] s);
    @(posedge mclk);
    addr_sel <= a;
    mode_sel <= md;
    misc_sel <= s;
    rst <= 1'h1;
    repeat (8) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    #1;
    `CHK("addr", {2'h0, a}, mgmt_addr)
    `CHK("latched", 1'h1, straps_latched)
    `CHK("mode", md == 3'h1 ? strap_led_pkg::MODE_RMII : md == 3'h4 ?
      strap_led_pkg::MODE_PCS_LOOPBACK : strap_led_pkg::MODE_MII,
      if_mode)
    chk_rd(5'h00, {2'h0, s[2], s[0], 1'h0, s[3], 1'h0, s[1],
      8'h00});
    chk_rd(5'h04, 16'h0061 | (s[2] ? 16'h0180 : 16'h0000));
    chk_rd(5'h05, 16'h0000);
  endtask : restart
  // watchdog
  initial begin
    #200_000;
    mismatches++;
    results();
  end
  // main sequence
  initial begin
    rst = 1'h1;
    {reg_wr, reg_rd, link_up, link_speed_100, activity} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    void'($urandom(21622));
    restart(3'h1, 3'h0, 4'h7);
    for (int i = 0; i < 6; i++) begin
      restart(3'($urandom_range(7, 1)), i[0] ? 3'h1 : (i[1] ? 3'h4 : 3'h0),
        4'($urandom));
    end
    v = 16'($urandom);
    wr(5'h00, v);
    chk_rd(5'h00, v);
    wr(5'h04, ~v);
    chk_rd(5'h04, ~v);
    // unmapped write leaves nothing behind
    wr(5'h05, v);
    chk_rd(5'h05, 16'h0000);
    // every led mode against the bench model
    for (int k = 0; k < 4; k++) begin
      m = 2'(k);
      v = {m, 14'($urandom)};
      wr(5'h1e, v);
      chk_rd(5'h1e, v);
      for (int j = 0; j < 10; j++) begin
        @(posedge mclk);
        link_up <= 1'($urandom);
        link_speed_100 <= 1'($urandom);
        activity <= (m == 2'h0) ? 1'h0 : 1'($urandom);
        repeat (2) @(posedge mclk);
        #1;
        `CHK("leds", m == 2'h0 ? {!link_speed_100, !link_up} : m == 2'h1 ?
          {!activity, !link_up} : 2'h3, ~led_lit)
      end
    end
    // link with activity blinks in mode 00
    wr(5'h1e, 16'h0000);
    link_up <= 1'h1;
    activity <= 1'h1;
    lit = 0;
    repeat (16) begin
      @(posedge mclk);
      #1;
      lit += int'(led_lit[0]);
    end
    `CHK("blink", 8, lit)
    results();
  end
endmodule : phy_strap_latch_led_ctrl_test
`default_nettype wire
